// file: hw/lsm_map.svh
// constants for the logic supply monitor supervisor
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define LSM_CLK_PERIOD_NS     25
`define LSM_FILTER_TIME_US    100
`define LSM_FILTER_MIN_US     60
`define LSM_FILTER_MAX_US     135
`define LSM_POR_DELAY_MAX_US  500
// least times round up, longest times round down
`define LSM_FILTER_CYCLES     ((`LSM_FILTER_TIME_US * 1000 + `LSM_CLK_PERIOD_NS - 1) / `LSM_CLK_PERIOD_NS)
`define LSM_FILTER_MIN_CYC    ((`LSM_FILTER_MIN_US * 1000 + `LSM_CLK_PERIOD_NS - 1) / `LSM_CLK_PERIOD_NS)
`define LSM_FILTER_MAX_CYC    ((`LSM_FILTER_MAX_US * 1000) / `LSM_CLK_PERIOD_NS)
`define LSM_POR_DELAY_CYCLES  ((`LSM_POR_DELAY_MAX_US * 1000) / `LSM_CLK_PERIOD_NS)

// -----------------------------------------------------------------
// monitor status and control register fields
// -----------------------------------------------------------------
`define LSM_REG_W             8
`define LSM_BIT_OV_OK         0
`define LSM_BIT_UV_OK         1
`define LSM_BIT_SUPPLY_OK     2
`define LSM_BIT_OV_LATCHED    4
`define LSM_BIT_LATCH_SEL     5
`define LSM_BIT_TEST_SEL      6
`define LSM_BIT_TEST_END      7
`define LSM_LATCH_SEL_RST     1'B0

`endif

// file: hw/lsm_pkg.sv
// types for the logic supply monitor supervisor
package lsm_pkg;
   // gray along off -> delay -> run <-> fault
   typedef enum logic [1:0] {
      LSM_OFF   = 2'H0,
      LSM_DELAY = 2'H1,
      LSM_RUN   = 2'H3,
      LSM_FAULT = 2'H2
   } lsm_state_t;

   typedef enum logic [1:0] {
      LSM_TEST_NONE = 2'H0,
      LSM_TEST_OV   = 2'H1,
      LSM_TEST_UV   = 2'H2
   } lsm_test_t;
endpackage

// file: hw/lsm_flt_if.sv
// comparator-to-filter link of the supply monitor
`timescale 1ns/1ps
`default_nettype none
interface lsm_flt_if;
   logic raw;
   logic clear;
   logic filtered;
   modport filter (input raw, input clear, output filtered);
   modport owner  (output raw, output clear, input filtered);
endinterface
`default_nettype wire

// file: hw/lsm_glitch_filter.sv
// glitch filter: output follows input after a stable run of cycles
`timescale 1ns/1ps
`default_nettype none
module lsm_glitch_filter #(
   parameter int CYCLES = 4000
) (
   input  wire logic   clk,
   input  wire logic   reset_n,
   lsm_flt_if.filter   flt
);
   localparam int CW = $clog2(CYCLES + 1);

   initial begin
      if (CYCLES < 2) $error("lsm_glitch_filter: CYCLES must be at least 2");
   end

   logic [CW-1:0] cnt_ff;
   logic          filtered_ff;

   // -----------------------------------------------------------------
   // stability counter
   // -----------------------------------------------------------------
   // count restarts whenever raw agrees with the output again
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff      <= '0;
         filtered_ff <= 1'B0;
      end else if (flt.clear) begin
         cnt_ff      <= '0;
         filtered_ff <= 1'B0;
      end else if (flt.raw == filtered_ff) begin
         cnt_ff <= '0;
      end else if (cnt_ff == CW'(CYCLES - 1)) begin
         cnt_ff      <= '0;
         filtered_ff <= flt.raw;
      end else begin
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   assign flt.filtered = filtered_ff;

   a_filter_no_glitch: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(flt.raw) && !flt.clear |=> !$changed(filtered_ff))
      else $error("filter output moved one cycle after an input change");
   a_filter_needs_run: assert property (@(posedge clk) disable iff (!reset_n)
      !flt.clear && (flt.raw != filtered_ff) && (cnt_ff == '0) |=> filtered_ff == $past(filtered_ff))
      else $error("filter output moved before the stable count ran out");
endmodule
`default_nettype wire

// file: hw/lsm_supervisor.sv
// logic supply monitor supervisor: reset sequence, window filter, enable line
// -----------------------------------------------------------------
// Overview of operation
// - functional reset holds stages off, clears state
// - run only after power-on-reset delay elapses
// - supply outside window: stages off, line low
// - window comparison passes through glitch filter
// - monitor state readable in status register
// - external low on line turns stages off
// - fault refuses switch-on, switch-off always works
// - below power-on level: immediate unfiltered shutdown
// - flag mode: monitoring on, no test, no latch
// - control and fault detail only in serial mode
// - undervoltage off/on after filter times
// - fault blocks diagnostic logging, keeps configuration writes
// - rising above power-on level resets all registers
// - overvoltage shuts stages off after filter
// - latch set keeps line low until reset/rewrite
// - latch clear releases after supply and filter
// - pattern 00 lowers overvoltage level; bits 2,0 low
// - pattern 01 raises undervoltage level; bits 2,1 low
// - low output-buffer supply selects status-flag mode
// - filter interval between 60 and 135 microseconds
// - power-on-reset delay at most 0.5 milliseconds
// -----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "lsm_map.svh"
module lsm_supervisor
   import lsm_pkg::*;
#(
   parameter int FILTER_CYCLES = `LSM_FILTER_CYCLES,
   parameter int POR_CYCLES    = `LSM_POR_DELAY_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 above_functional_reset_level,
   input  wire logic                 above_power_on_reset_level,
   input  wire logic                 below_undervoltage_level,
   input  wire logic                 above_overvoltage_level,
   input  wire logic                 below_undervoltage_test_level,
   input  wire logic                 above_overvoltage_test_level,
   input  wire logic                 io_buffer_supply_low,
   input  wire logic                 reg_wr_en,
   input  wire logic [`LSM_REG_W-1:0] reg_wr_data,
   output logic [`LSM_REG_W-1:0]     monitor_status_control_register,
   input  wire logic                 bridge_enable_line_n_i,
   output logic                      bridge_enable_line_n_o,
   output logic                      bridge_enable_line_n_oe,
   input  wire logic                 out_one_on_req,
   input  wire logic                 out_two_on_req,
   output logic                      bridge_output_one,
   output logic                      bridge_output_two,
   output logic                      status_flag_mode,
   output logic                      diag_log_enable,
   output logic                      supply_fault
);
   // the filter default sits inside its allowed window at the nominal clock;
   // shorter counts only serve shortened simulation runs
   localparam int PW = $clog2(POR_CYCLES + 1);

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   initial begin
      if (FILTER_CYCLES < 2) $error("lsm_supervisor: FILTER_CYCLES below 2");
      if (POR_CYCLES < 16) $error("lsm_supervisor: POR_CYCLES below 16");
   end

   lsm_state_t            state_ff;
   lsm_state_t            nxt_state;
   lsm_test_t             test_ff;
   logic [PW-1:0]         por_cnt_ff;
   logic                  latch_sel_ff;
   logic                  ov_latched_ff;
   logic                  out_one_ff;
   logic                  out_two_ff;
   logic [`LSM_REG_W-1:0] status_ff;
   logic                  cleared;
   logic                  serial_wr;
   logic                  fault;
   logic                  permit;

   lsm_flt_if ov_flt ();
   lsm_flt_if uv_flt ();

   // -----------------------------------------------------------------
   // mode select and window comparison
   // -----------------------------------------------------------------
   assign status_flag_mode = io_buffer_supply_low;
   // register writes only reach the monitor in serial mode
   assign serial_wr = reg_wr_en && !status_flag_mode;
   assign cleared   = (state_ff == LSM_OFF);

   // test thresholds are selected only while a test is running
   assign ov_flt.raw = (test_ff == LSM_TEST_OV) ? above_overvoltage_test_level
                                                 : above_overvoltage_level;
   assign uv_flt.raw = (test_ff == LSM_TEST_UV) ? below_undervoltage_test_level
                                                 : below_undervoltage_level;
   assign ov_flt.clear = cleared;
   assign uv_flt.clear = cleared;

   lsm_glitch_filter #(.CYCLES(FILTER_CYCLES)) u_ov_filter (
      .clk     (clk),
      .reset_n (reset_n),
      .flt     (ov_flt)
   );
   lsm_glitch_filter #(.CYCLES(FILTER_CYCLES)) u_uv_filter (
      .clk     (clk),
      .reset_n (reset_n),
      .flt     (uv_flt)
   );

   // power-on level bypasses the filters entirely
   assign fault = !above_power_on_reset_level || ov_flt.filtered
               || uv_flt.filtered || ov_latched_ff;
   assign supply_fault = fault;

   // -----------------------------------------------------------------
   // reset sequence
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         LSM_OFF: begin
            if (above_functional_reset_level && above_power_on_reset_level) begin
               nxt_state = LSM_DELAY;
            end
         end
         LSM_DELAY: begin
            if (por_cnt_ff == PW'(POR_CYCLES - 1)) begin
               nxt_state = fault ? LSM_FAULT : LSM_RUN;
            end
         end
         LSM_RUN: begin
            if (fault) begin
               nxt_state = LSM_FAULT;
            end
         end
         LSM_FAULT: begin
            if (!fault) begin
               nxt_state = LSM_RUN;
            end
         end
      endcase
      if (!above_functional_reset_level || !above_power_on_reset_level) begin
         nxt_state = LSM_OFF;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= LSM_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_cnt_ff <= '0;
      end else if (state_ff != LSM_DELAY) begin
         por_cnt_ff <= '0;
      end else if (por_cnt_ff != PW'(POR_CYCLES - 1)) begin
         por_cnt_ff <= por_cnt_ff + PW'(1);
      end
   end

   // -----------------------------------------------------------------
   // monitor control: test select, latch select, overvoltage latch
   // -----------------------------------------------------------------
   // a test start is only honoured in serial mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         test_ff <= LSM_TEST_NONE;
      end else if (cleared || status_flag_mode) begin
         test_ff <= LSM_TEST_NONE;
      end else if (serial_wr) begin
         if (reg_wr_data[`LSM_BIT_TEST_END]) begin
            test_ff <= LSM_TEST_NONE;
         end else if (reg_wr_data[`LSM_BIT_TEST_SEL]) begin
            test_ff <= LSM_TEST_UV;
         end else begin
            test_ff <= LSM_TEST_OV;
         end
      end
   end

   // configuration stays writable during a supply fault
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_sel_ff <= `LSM_LATCH_SEL_RST;
      end else if (cleared) begin
         latch_sel_ff <= `LSM_LATCH_SEL_RST;
      end else if (serial_wr) begin
         latch_sel_ff <= reg_wr_data[`LSM_BIT_LATCH_SEL];
      end
   end

   // set wins over a clearing write in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ov_latched_ff <= 1'B0;
      end else if (cleared) begin
         ov_latched_ff <= 1'B0;
      end else if (ov_flt.filtered && latch_sel_ff && !status_flag_mode) begin
         ov_latched_ff <= 1'B1;
      end else if (serial_wr) begin
         ov_latched_ff <= 1'B0;
      end
   end

   // -----------------------------------------------------------------
   // enable line and power stages
   // -----------------------------------------------------------------
   // open drain: only ever pulls low, never drives high
   assign bridge_enable_line_n_o  = 1'B0;
   assign bridge_enable_line_n_oe = (state_ff != LSM_RUN) || fault;

   // the line is read back so an external low also stops the stages
   assign permit = (state_ff == LSM_RUN) && !fault && bridge_enable_line_n_i;

   // requests are held but gated combinationally so switch-off is instant
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_one_ff <= 1'B0;
         out_two_ff <= 1'B0;
      end else if (cleared) begin
         out_one_ff <= 1'B0;
         out_two_ff <= 1'B0;
      end else begin
         out_one_ff <= out_one_on_req;
         out_two_ff <= out_two_on_req;
      end
   end

   assign bridge_output_one = out_one_ff && permit;
   assign bridge_output_two = out_two_ff && permit;
   assign diag_log_enable   = (state_ff == LSM_RUN) && !fault;

   // -----------------------------------------------------------------
   // status readback
   // -----------------------------------------------------------------
   // ok bits are active high; fault detail is hidden in flag mode
   // in the off state the ok bits show the cleared filters and supply ok stays low only while below the power-on level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_ff <= '0;
      end else if (status_flag_mode) begin
         status_ff <= '0;
      end else begin
         status_ff                      <= '0;
         status_ff[`LSM_BIT_OV_OK]      <= !ov_flt.filtered;
         status_ff[`LSM_BIT_UV_OK]      <= !uv_flt.filtered;
         status_ff[`LSM_BIT_SUPPLY_OK]  <= !fault;
         status_ff[`LSM_BIT_OV_LATCHED] <= ov_latched_ff;
         status_ff[`LSM_BIT_LATCH_SEL]  <= latch_sel_ff;
      end
   end

   assign monitor_status_control_register = status_ff;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_por_immediate_off: assert property (@(posedge clk) disable iff (!reset_n)
      !above_power_on_reset_level |-> bridge_enable_line_n_oe
         && !bridge_output_one && !bridge_output_two)
      else $error("stage on or line released below power-on level");
   a_fault_refuse_on: assert property (@(posedge clk) disable iff (!reset_n)
      fault && bridge_enable_line_n_i |-> !bridge_output_one && !bridge_output_two)
      else $error("stage on during supply fault");
   a_ext_line_off: assert property (@(posedge clk) disable iff (!reset_n)
      !bridge_enable_line_n_i |-> !bridge_output_one && !bridge_output_two)
      else $error("stage on while enable line held low");
   a_por_delay_hold: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state_ff == LSM_DELAY)
         ##1 (above_power_on_reset_level && above_functional_reset_level) [*7]
         |-> state_ff == LSM_DELAY && !permit)
      else $error("power-on delay ended early");
   a_flag_no_test: assert property (@(posedge clk) disable iff (!reset_n)
      status_flag_mode |=> test_ff == LSM_TEST_NONE || !$past(status_flag_mode))
      else $error("threshold test active in flag mode");
   a_flag_no_latch: assert property (@(posedge clk) disable iff (!reset_n)
      status_flag_mode && !ov_latched_ff |=> !ov_latched_ff)
      else $error("overvoltage latch set in flag mode");
   a_latch_holds: assert property (@(posedge clk) disable iff (!reset_n)
      ov_latched_ff && !serial_wr && !cleared |=> ov_latched_ff && bridge_enable_line_n_oe)
      else $error("overvoltage latch released without reset or write");
   a_diag_blocked: assert property (@(posedge clk) disable iff (!reset_n)
      fault |-> !diag_log_enable)
      else $error("diagnostic logging enabled during supply fault");
   a_status_ok_bits: assert property (@(posedge clk) disable iff (!reset_n)
      !status_flag_mode |=> status_ff[`LSM_BIT_SUPPLY_OK] == !$past(fault)
         && status_ff[`LSM_BIT_OV_OK] == !$past(ov_flt.filtered))
      else $error("status bits do not follow monitor state");
   a_test_ov_select: assert property (@(posedge clk) disable iff (!reset_n)
      serial_wr && !cleared && reg_wr_data[7:6] == 2'H0 |=> test_ff == LSM_TEST_OV)
      else $error("overvoltage test not entered on pattern 00");
endmodule
`default_nettype wire

// file: sim/lsm_host_model.sv
// host side of the shared enable wire: optional pull low, wire resolution
`timescale 1ns/1ps
`default_nettype none
module lsm_host_model (
   input  wire logic dev_oe,
   input  wire logic host_pull,
   output var  logic line
);
   // open drain: either party pulls low, board pull-up gives high
   always_comb begin
      line = !(dev_oe || host_pull);
   end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the logic supply monitor supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lsm_map.svh"
module testbench;
   import lsm_pkg::*;
   localparam int FC = 4;
   localparam int PC = 16;
   logic                  clk, reset_n, func_ok, por_ok, uv, ov, uv_t, ov_t, io_low;
   logic                  wr_en, req1, req2, host_pull, line, oe, lo, o1, o2, sfm, dle, flt;
   logic [`LSM_REG_W-1:0] wr_data, rb;
   int                    failures, tests_run, cycles;

   lsm_supervisor #(.FILTER_CYCLES(FC), .POR_CYCLES(PC)) u_lsm_supervisor (
      .clk(clk), .reset_n(reset_n), .above_functional_reset_level(func_ok),
      .above_power_on_reset_level(por_ok), .below_undervoltage_level(uv),
      .above_overvoltage_level(ov), .below_undervoltage_test_level(uv_t),
      .above_overvoltage_test_level(ov_t), .io_buffer_supply_low(io_low),
      .reg_wr_en(wr_en), .reg_wr_data(wr_data), .monitor_status_control_register(rb),
      .bridge_enable_line_n_i(line), .bridge_enable_line_n_o(lo),
      .bridge_enable_line_n_oe(oe), .out_one_on_req(req1), .out_two_on_req(req2),
      .bridge_output_one(o1), .bridge_output_two(o2), .status_flag_mode(sfm),
      .diag_log_enable(dle), .supply_fault(flt));
   lsm_host_model u_lsm_host_model (.dev_oe(oe), .host_pull(host_pull), .line(line));

   // --------------------------------------------------------------
   // clock, timeout, helpers
   // --------------------------------------------------------------
   initial clk = 1'B0;
   always #12.5 clk = !clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // generous ceiling: the sequence needs well under 1000 cycles
      if (cycles == 5000) begin
         failures = failures + 1;
         end_of_test();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'B1;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'B0;
   endtask
   task automatic outs(input logic on, input string what);
      check({7'H00, o1}, {7'H00, on}, what);
      check({7'H00, o2}, {7'H00, on}, what);
      check({7'H00, oe}, {7'H00, !on}, what);
      check({7'H00, lo}, 8'H00, what);
   endtask
   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, failures);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      failures = 0; tests_run = 0; cycles = 0;
      reset_n = 1'B0; func_ok = 1'B0; por_ok = 1'B0; uv = 1'B0; ov = 1'B0;
      uv_t = 1'B1; ov_t = 1'B1; io_low = 1'B0; wr_en = 1'B0; wr_data = 8'H00;
      req1 = 1'B1; req2 = 1'B1; host_pull = 1'B0;
      cyc(16);
      outs(1'B0, "reset holds stages off");
      check(rb, 8'H00, "reset clears register");
      reset_n = 1'B1;
      cyc(2);
      func_ok = 1'B1;
      por_ok = 1'B1;
      cyc(3);
      outs(1'B0, "delay before run");
      cyc(PC + 4);
      outs(1'B1, "run after delay");
      check(rb, 8'H07, "normal status");
      wr(8'H80); // latch off before any threshold
      done("power_up");
      // short undervoltage runs never reach the filter count
      uv = 1'B1; cyc(FC - 1); uv = 1'B0; cyc(1); uv = 1'B1; cyc(FC - 1); uv = 1'B0;
      cyc(FC + 2);
      outs(1'B1, "glitches ignored");
      uv = 1'B1;
      cyc(2);
      outs(1'B1, "undervoltage still filtered");
      cyc(FC + 4);
      outs(1'B0, "undervoltage shutdown");
      check({7'H00, flt}, 8'H01, "fault flag");
      check({7'H00, dle}, 8'H00, "no logging in fault");
      check(rb, 8'H01, "undervoltage reported");
      req1 = 1'B0; req2 = 1'B0; cyc(2); req1 = 1'B1; req2 = 1'B1; cyc(2);
      outs(1'B0, "switch on refused");
      wr(8'HA0);
      cyc(1);
      check(rb, 8'H21, "configuration write in fault");
      req1 = 1'B0;
      req2 = 1'B0;
      wr(8'H80);
      uv = 1'B0;
      cyc(FC + 6);
      check({6'H00, o1, o2}, 8'H00, "outputs wait for host rewrite");
      req1 = 1'B1; // host rewrites its requests after recovery
      req2 = 1'B1;
      cyc(1);
      outs(1'B1, "undervoltage recovery");
      check({7'H00, dle}, 8'H01, "logging back");
      done("undervoltage");
      wr(8'HA0);
      ov = 1'B1;
      cyc(FC + 6);
      outs(1'B0, "overvoltage shutdown");
      check({7'H00, rb[0]}, 8'H00, "overvoltage reported");
      check({7'H00, rb[4]}, 8'H01, "latch recorded");
      ov = 1'B0;
      cyc(FC + 6);
      outs(1'B0, "latched after overvoltage");
      wr(8'H80);
      cyc(FC + 6);
      outs(1'B1, "rewrite releases latch");
      check(rb, 8'H07, "status after release");
      ov = 1'B1; cyc(FC + 6);
      outs(1'B0, "overvoltage without latch");
      ov = 1'B0; cyc(FC + 6);
      outs(1'B1, "auto recovery without latch");
      done("overvoltage");
      // test of lowered upper then raised lower threshold
      wr(8'H00); cyc(FC + 4);
      check(rb, 8'H02, "upper threshold test");
      wr(8'H80); cyc(FC + 4);
      check(rb, 8'H07, "upper test ended");
      wr(8'H40); cyc(FC + 4);
      check(rb, 8'H01, "lower threshold test");
      wr(8'H80); cyc(FC + 6);
      check(rb, 8'H07, "lower test ended");
      outs(1'B1, "run after tests");
      done("threshold_test");
      host_pull = 1'B1; cyc(2);
      check({6'H00, o1, o2}, 8'H00, "external disable");
      host_pull = 1'B0; cyc(2);
      check({6'H00, o1, o2}, 8'H03, "external release");
      done("external_enable");
      // latch selected before flag mode, so a latch there would show
      wr(8'HA0);
      io_low = 1'B1; cyc(2);
      check({7'H00, sfm}, 8'H01, "flag mode entered");
      check(rb, 8'H00, "no detail in flag mode");
      wr(8'H00); cyc(FC + 4);
      outs(1'B1, "no test in flag mode");
      uv = 1'B1; cyc(FC + 6);
      outs(1'B0, "monitoring in flag mode");
      uv = 1'B0; cyc(FC + 6);
      ov = 1'B1; cyc(FC + 6);
      outs(1'B0, "overvoltage in flag mode");
      ov = 1'B0; cyc(FC + 6);
      outs(1'B1, "no overvoltage latch in flag mode");
      io_low = 1'B0; cyc(2);
      outs(1'B1, "serial mode again");
      check(rb, 8'H27, "status in serial mode");
      done("flag_mode");
      wr(8'HA0); cyc(1);
      @(negedge clk);
      por_ok = 1'B0;
      #1;
      outs(1'B0, "immediate power-on shutdown");
      cyc(3);
      // latch select cleared; ok bits show the cleared filters
      check(rb, 8'H03, "registers cleared");
      por_ok = 1'B1;
      cyc(PC + FC + 8);
      outs(1'B1, "restart after power-on reset");
      check(rb, 8'H07, "defaults after power-on reset");
      done("power_on_reset");
      end_of_test();
   end
endmodule
`default_nettype wire
